// >>> shared/exec_pkg.sv
// shared constants, types and helpers for the file-register and branch execution unit
package exec_pkg;

    localparam int DATA_W       = 8;
    localparam int FADDR_W      = 7;
    localparam int LIT_W        = 11;
    localparam int PC_W         = 15;
    localparam int LATCH_W      = 8;
    localparam int PAGE_LO      = 3;   // page latch bits feeding the program counter top
    localparam int PAGE_HI      = 6;
    localparam int CLK_PER_ICYC = 4;   // core clocks per instruction cycle
    localparam int ICYC_CNT_W   = 2;
    localparam int CYC_W        = 2;

    localparam logic [CYC_W-1:0]   ONE_CYCLE  = 2'h1;
    localparam logic [CYC_W-1:0]   TWO_CYCLES = 2'h2;
    localparam logic [DATA_W-1:0]  ZERO_BYTE  = 8'h00;
    localparam logic [DATA_W-1:0]  ONE_BYTE   = 8'h01;
    localparam logic [PC_W-1:0]    PC_RESET   = 15'h0000;

    typedef enum logic [2:0] {
        complement_file_op     = 3'h0,
        zero_file_op           = 3'h1,
        decrement_file_op      = 3'h2,
        zero_working_op        = 3'h3,
        decrement_skip_zero_op = 3'h4,
        increment_skip_zero_op = 3'h5,
        absolute_jump_op       = 3'h6,
        no_op                  = 3'h7
    } op_t;

    // one decoded instruction as handed over by the core
    typedef struct packed {
        op_t                op;
        logic [FADDR_W-1:0] faddr;
        logic               dest;   // 0: working register, 1: file register
        logic [LIT_W-1:0]   lit;
    } instr_t;

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return v == ZERO_BYTE;
    endfunction

endpackage

// >>> design/file_ram.sv
// data-memory bank of file registers, synchronous write, registered read data
`timescale 1ns/1ps
module file_ram #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // array has no reset; contents are undefined until software writes them
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read data is held in a register so the result path starts from a flop
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// >>> design/file_exec.sv
// execution unit for file-register ops, working-register clear, skips and absolute jump
`timescale 1ns/1ps
module file_exec
    import exec_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic               instr_valid,
    input  wire instr_t             instr,
    input  wire logic [LATCH_W-1:0] program_page_latch,
    output logic                    ready,
    output logic                    done,
    output logic                    discard_next,
    output logic                    pc_load,
    output logic [PC_W-1:0]         pc,
    output logic [DATA_W-1:0]       w_reg,
    output logic                    zero_flag
);
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_READ = 2'b01,
        S_WAIT = 2'b11
    } state_t;

    state_t                  state;
    state_t                  next_state;
    instr_t                  cur;
    logic [ICYC_CNT_W-1:0]   qcnt;
    logic [CYC_W-1:0]        cyc_left;
    logic                    discard_pend;

    // instruction-cycle enable: one pulse every CLK_PER_ICYC clocks
    wire icyc_tick = (qcnt == ICYC_CNT_W'(CLK_PER_ICYC - 1));
    // instructions start only on an instruction-cycle boundary
    wire take      = ready && instr_valid && icyc_tick;
    wire in_read   = (state == S_READ);
    wire [DATA_W-1:0] rd_data;

    // result selection
    wire is_comp  = (cur.op == complement_file_op);
    wire is_zf    = (cur.op == zero_file_op);
    wire is_dec   = (cur.op == decrement_file_op);
    wire is_zw    = (cur.op == zero_working_op);
    wire is_dsk   = (cur.op == decrement_skip_zero_op);
    wire is_isk   = (cur.op == increment_skip_zero_op);
    wire is_jump  = (cur.op == absolute_jump_op);
    wire is_skip  = is_dsk || is_isk;
    wire [DATA_W-1:0] dec_val = rd_data - ONE_BYTE;
    wire [DATA_W-1:0] inc_val = rd_data + ONE_BYTE;
    wire [DATA_W-1:0] result  = is_comp ? ~rd_data :
                                (is_dec || is_dsk) ? dec_val :
                                is_isk ? inc_val : ZERO_BYTE;
    wire res_zero   = is_zero(result);
    wire has_result = is_comp || is_dec || is_skip;
    // one-bit dest steers file vs working
    wire to_file    = has_result && cur.dest;
    wire to_w       = (has_result && !cur.dest) || is_zw;
    wire mem_we     = in_read && (to_file || is_zf);
    wire [DATA_W-1:0] mem_wdata = result;
    wire upd_zero   = is_comp || is_dec;
    wire set_zero   = is_zf || is_zw;
    wire skip_hit   = is_skip && res_zero;
    // jump, and a skip whose result is zero, take two cycles
    wire [CYC_W-1:0] ncyc = (is_jump || skip_hit) ? TWO_CYCLES : ONE_CYCLE;
    // jump target from literal and page latch
    wire [PC_W-1:0] jump_pc = {program_page_latch[PAGE_HI:PAGE_LO], cur.lit};

    // seven-bit file address into the bank
    file_ram #(.AW(FADDR_W), .DW(DATA_W)) u_ram (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .rd_en   (take),
        .rd_addr (instr.faddr),
        .rd_data (rd_data),
        .wr_en   (mem_we),
        .wr_addr (cur.faddr),
        .wr_data (mem_wdata)
    );

    // next state
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (take) begin
                    next_state = S_READ;
                end
            end
            S_READ: next_state = S_WAIT;
            S_WAIT: begin
                if (icyc_tick && cyc_left == ONE_CYCLE) begin
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    // free-running divider for the instruction cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            qcnt <= '0;
        end else begin
            qcnt <= icyc_tick ? '0 : qcnt + ICYC_CNT_W'(1);
        end
    end

    // sequencing and cycle accounting
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= S_IDLE;
            cur          <= '{op: no_op, faddr: '0, dest: 1'b0, lit: '0};
            cyc_left     <= ONE_CYCLE;
            discard_pend <= 1'b0;
            ready        <= 1'b1;
            done         <= 1'b0;
            discard_next <= 1'b0;
        end else begin
            state <= next_state;
            done  <= 1'b0;
            discard_next <= 1'b0;
            if (take) begin
                cur   <= instr;
                ready <= 1'b0;
            end
            if (in_read) begin
                cyc_left     <= ncyc;
                discard_pend <= is_jump || skip_hit;
            end
            if (state == S_WAIT && icyc_tick) begin
                cyc_left <= cyc_left - ONE_CYCLE;
                if (cyc_left == ONE_CYCLE) begin
                    done         <= 1'b1;
                    discard_next <= discard_pend;
                    ready        <= 1'b1;
                end
            end
        end
    end

    // architectural results; skip ops leave the zero flag untouched
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            w_reg     <= ZERO_BYTE;
            zero_flag <= 1'b0;
            pc        <= PC_RESET;
            pc_load   <= 1'b0;
        end else begin
            pc_load <= 1'b0;
            if (in_read) begin
                if (to_w) begin
                    w_reg <= result;
                end
                // zero flag from the 8-bit result
                if (upd_zero) begin
                    zero_flag <= res_zero;
                end else if (set_zero) begin
                    zero_flag <= 1'b1;
                end
                if (is_jump) begin
                    pc      <= jump_pc;
                    pc_load <= 1'b1;
                end
            end
        end
    end

    // helper: clocks since the instruction was taken, for cycle checks
    logic [7:0]       elapsed;
    logic [CYC_W-1:0] took_cyc;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            elapsed  <= '0;
            took_cyc <= ONE_CYCLE;
        end else begin
            elapsed <= take ? 8'h00 : elapsed + 8'h01;
            if (in_read) begin
                took_cyc <= ncyc;
            end
        end
    end

    AST_COMP_W: assert property (@(posedge mclk) disable iff (!rst_n)
        in_read && is_comp && !cur.dest |=> w_reg == ~$past(rd_data))
        else $error("complement to working register wrong");
    AST_ZERO_FILE: assert property (@(posedge mclk) disable iff (!rst_n)
        in_read && is_zf |-> mem_we && mem_wdata == ZERO_BYTE ##1 zero_flag)
        else $error("clear-file did not write zero and set zero flag");
    AST_DEC_FILE: assert property (@(posedge mclk) disable iff (!rst_n)
        in_read && is_dec && cur.dest |-> mem_we && mem_wdata == rd_data - ONE_BYTE)
        else $error("decrement to file wrong");
    AST_ZERO_W: assert property (@(posedge mclk) disable iff (!rst_n)
        in_read && is_zw |=> w_reg == ZERO_BYTE && zero_flag)
        else $error("clear-working did not clear w and set zero");
    AST_SKIP_FLAGS: assert property (@(posedge mclk) disable iff (!rst_n)
        in_read && is_skip |=> $stable(zero_flag))
        else $error("skip op changed the zero flag");
    AST_SKIP_DISCARD: assert property (@(posedge mclk) disable iff (!rst_n)
        in_read && skip_hit |-> ##8 done && discard_next)
        else $error("skip on zero did not discard over two cycles");
    AST_SKIP_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
        in_read && is_skip && !skip_hit |-> ##4 done && !discard_next)
        else $error("skip on nonzero discarded or finished late");
    AST_JUMP_PC: assert property (@(posedge mclk) disable iff (!rst_n)
        in_read && is_jump |=> pc_load && $stable(zero_flag)
            && pc == {$past(program_page_latch[PAGE_HI:PAGE_LO]), $past(cur.lit)})
        else $error("jump target or flags wrong");
    AST_CYCLES: assert property (@(posedge mclk) disable iff (!rst_n)
        done |-> elapsed == 8'(CLK_PER_ICYC * int'(took_cyc))
            && discard_next == (took_cyc == TWO_CYCLES))
        else $error("instruction cycle count or discard wrong");
    AST_ZERO_UPD: assert property (@(posedge mclk) disable iff (!rst_n)
        in_read && upd_zero |=> zero_flag == is_zero($past(result)))
        else $error("zero flag does not match result");
    AST_ADDR: assert property (@(posedge mclk) disable iff (!rst_n)
        take |=> cur.faddr == $past(instr.faddr) && cur.dest == $past(instr.dest))
        else $error("operand capture wrong");
endmodule

// >>> tb/file_exec_test.sv
// self-checking bench for the file-register and jump execution unit
`timescale 1ns/1ps
module file_exec_test;
    import exec_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] w;
        logic              z;
        logic              disc;
        logic [PC_W-1:0]   pc;
        logic [7:0]        loads;
        logic [7:0]        span;
        logic [31:0]       take;
    } note_t;

    logic               mclk = 1'b0;
    logic               rst_n = 1'b0;
    logic               instr_valid = 1'b0;
    instr_t             instr = '0;
    logic [LATCH_W-1:0] program_page_latch = 8'h00;
    logic               ready, done, discard_next, pc_load, zero_flag;
    logic [PC_W-1:0]    pc;
    logic [DATA_W-1:0]  w_reg;
    logic [DATA_W-1:0]  mem [128];
    logic [DATA_W-1:0]  m_w = 8'h00;
    logic               m_z = 1'b0;
    logic [PC_W-1:0]    m_pc = 15'h0000;
    logic [7:0]         m_loads = 8'h00;
    logic [7:0]         seen_loads = 8'h00;
    logic [31:0]        cyc = 32'h0;
    logic [15:0]        seed = 16'h0001;
    note_t              notes [$];
    note_t              cur;
    int                 bad_count = 0;
    int                 num_checks = 0;

    file_exec u_file_exec (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr(instr), .program_page_latch(program_page_latch), .ready(ready), .done(done),
        .discard_next(discard_next), .pc_load(pc_load), .pc(pc), .w_reg(w_reg),
        .zero_flag(zero_flag));

    // 10 MHz core clock
    always #50 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 32'h1;

    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // reference model first, then drive until the take and wait for completion
    task automatic run(input op_t o, input logic [6:0] a, input logic d,
                       input logic [10:0] l, input logic [7:0] latch);
        note_t      n;
        logic [7:0] r;
        int         k;
        n = '0;
        r = mem[a];
        case (o)
            complement_file_op: r = ~r;
            decrement_file_op, decrement_skip_zero_op: r = r - 8'h01;
            increment_skip_zero_op: r = r + 8'h01;
            default: r = ZERO_BYTE;
        endcase
        if (o inside {complement_file_op, decrement_file_op, decrement_skip_zero_op,
                      increment_skip_zero_op}) begin
            if (d) mem[a] = r;
            else m_w = r;
        end
        if (o == zero_file_op) mem[a] = ZERO_BYTE;
        if (o == zero_working_op) m_w = ZERO_BYTE;
        // skips and the jump leave the flag alone
        if (o inside {complement_file_op, zero_file_op, decrement_file_op, zero_working_op})
            m_z = (r == ZERO_BYTE);
        n.disc = (o == absolute_jump_op) ||
                 ((o inside {decrement_skip_zero_op, increment_skip_zero_op}) && r == ZERO_BYTE);
        if (o == absolute_jump_op) begin
            m_pc = {latch[PAGE_HI:PAGE_LO], l};
            m_loads = m_loads + 8'h01;
        end
        n.span = n.disc ? 8'h08 : 8'h04;
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr <= '{op: o, faddr: a, dest: d, lit: l};
        program_page_latch <= latch;
        for (k = 0; k < 16; k++) begin
            @(posedge mclk);
            #1;
            if (ready === 1'b0) break;
        end
        if (k == 16) begin
            bad_count++;
            final_report();
        end
        n.take = cyc;
        n.w = m_w;
        n.z = m_z;
        n.pc = m_pc;
        n.loads = m_loads;
        notes.push_back(n);
        // valid stays up one more edge, where ready is low and it must be ignored
        @(posedge mclk);
        instr_valid <= 1'b0;
        for (k = 0; k < 16; k++) begin
            #1;
            if (ready === 1'b1) break;
            @(posedge mclk);
        end
        if (k == 16) begin
            bad_count++;
            final_report();
        end
        $display("test op %0d addr %h done", o, a);
    endtask

    // result watcher: settled values are sampled on the falling edge
    always @(negedge mclk) begin
        if (rst_n === 1'b1 && pc_load === 1'b1) seen_loads = seen_loads + 8'h01;
        if (rst_n === 1'b1 && discard_next === 1'b1) chk("discard with done", 1, done);
        if (rst_n === 1'b1 && done === 1'b1) begin
            if (notes.size() == 0) begin
                chk("note queue", 1, 0);
            end else begin
                cur = notes.pop_front();
                chk("w_reg", cur.w, w_reg);
                chk("zero_flag", cur.z, zero_flag);
                chk("discard_next", cur.disc, discard_next);
                chk("pc", cur.pc, pc);
                chk("pc_load count", cur.loads, seen_loads);
                chk("cycles", cur.span, cyc - cur.take);
            end
        end
    end

    initial begin
        logic [15:0] r2;
        repeat (20) @(posedge mclk);
        #1;
        chk("reset outputs", {1'b1, 3'h0, 15'h0000, 8'h00, 1'b0},
            {ready, done, discard_next, pc_load, pc, w_reg, zero_flag});
        @(posedge mclk);
        rst_n <= 1'b1;
        // clear the bank used below, including the top address
        for (int i = 0; i < 8; i++) run(zero_file_op, 7'(i), 1'b0, 11'h000, 8'h00);
        run(zero_file_op, 7'h7F, 1'b1, 11'h000, 8'h00);
        run(decrement_file_op, 7'h7F, 1'b0, 11'h000, 8'h00);
        run(increment_skip_zero_op, 7'h00, 1'b1, 11'h000, 8'h00);
        run(decrement_skip_zero_op, 7'h00, 1'b0, 11'h000, 8'h00);
        run(decrement_file_op, 7'h00, 1'b1, 11'h000, 8'h00);
        run(decrement_file_op, 7'h00, 1'b1, 11'h000, 8'h00);
        run(increment_skip_zero_op, 7'h00, 1'b0, 11'h000, 8'h00);
        run(complement_file_op, 7'h00, 1'b0, 11'h000, 8'h00);
        run(complement_file_op, 7'h00, 1'b1, 11'h000, 8'h00);
        run(absolute_jump_op, 7'h00, 1'b0, 11'h7FF, 8'hFF);
        run(absolute_jump_op, 7'h00, 1'b0, 11'h400, 8'h87);
        run(zero_working_op, 7'h00, 1'b0, 11'h000, 8'h00);
        // random mix over the cleared addresses
        for (int i = 0; i < 60; i++) begin
            seed = lfsr_step(seed);
            r2 = lfsr_step(seed);
            seed = r2;
            run(op_t'(r2[10:8]), {4'h0, r2[2:0]}, r2[7], r2[10:0] ^ 11'h5A3, r2[15:8]);
        end
        repeat (4) @(posedge mclk);
        chk("notes left", 0, notes.size());
        final_report();
    end
endmodule
